// ---- core/device_status_lock_regs.sv ----
`include "status_lock_params.svh"

module device_status_lock_regs
  import status_lock_pkg::*;
#(
  parameter logic [2:0] ID_HIGH_BITS  = 3'h0,  // Arbitrary neutral option code
  parameter logic [2:0] ID_LOW_BITS   = 3'h0,  // Arbitrary neutral option code
  parameter logic       EXT_SHORT_SEL = 1'b0,
  parameter int         EXT_LONG_CYC  = `SL_EXT_LONG_MS * `SL_CLK_PER_MS,
  parameter int         EXT_SHORT_CYC = `SL_EXT_SHORT_MS * `SL_CLK_PER_MS
) (
  // Clock and power-on reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // Device state from the sequencer
  input  wire logic [2:0] DEVICE_STATE_CODE,
  input  wire logic       IN_RESET_STATE,
  input  wire logic       LOGIC_SELFTEST_DONE,
  input  wire logic       REGULATOR_OVERVOLTAGE,
  // Battery-loss marker and latch value kept in the always-on domain
  input  wire logic       BATTERY_LOST,
  input  wire logic       RESTART_BLOCK_KEPT,
  // Command from the serial front end
  input  wire logic       CMD_VALID,
  input  wire logic [3:0] CMD_CODE,
  input  wire logic [7:0] CMD_DATA,
  // Read answer
  output logic            RESP_VALID,
  output logic [7:0]      RESP_DATA,
  // Writes passed to the protected registers
  output logic            CONFIG_WRITE,
  output logic            SELFTEST_WRITE,
  output logic            CONTROL_WRITE,
  output logic [7:0]      WRITE_DATA,
  // Lock and option levels to the rest of the device
  output logic            CONFIG_LOCKED,
  output logic            SELFTEST_LOCKED,
  output logic            CONTROL_LOCKED,
  output logic            AUTO_RESTART_BLOCK,
  output logic [31:0]     RESET_EXTENSION_CYCLES
);

  sl_state_t s_q;
  sl_state_t s_d;
  logic      loaded_q;
  logic      cmd_ok;
  logic      in_dsa;
  logic      was_dsa;
  logic      left_diag;
  logic      left_dsa;
  logic [7:0] identity;
  logic [7:0] status;
  cmd_t      cmd;

  assign cmd = cmd_t'(CMD_CODE);
  assign identity = {ID_HIGH_BITS, EXT_SHORT_SEL, 1'b0, ID_LOW_BITS};
  assign status = {DEVICE_STATE_CODE, 1'b0, s_q.restart_block,
                   s_q.cfg_lock, s_q.bist_lock, s_q.ctrl_lock};
  assign cmd_ok  = CMD_VALID;
  assign in_dsa  = (DEVICE_STATE_CODE == ST_DIAG) || (DEVICE_STATE_CODE == ST_ACTIVE)
                   || (DEVICE_STATE_CODE == ST_SAFE);
  assign was_dsa = (s_q.prev_state == ST_DIAG) || (s_q.prev_state == ST_ACTIVE)
                   || (s_q.prev_state == ST_SAFE);
  assign left_diag = (s_q.prev_state == ST_DIAG) && (DEVICE_STATE_CODE != ST_DIAG);
  assign left_dsa  = was_dsa && (DEVICE_STATE_CODE != s_q.prev_state);

  always_comb begin
    s_d = s_q;
    s_d.rvalid  = 1'b0;
    s_d.wr_cfg  = 1'b0;
    s_d.wr_bist = 1'b0;
    s_d.wr_ctrl = 1'b0;
    s_d.in_reset = IN_RESET_STATE;
    s_d.prev_state = DEVICE_STATE_CODE;
    if (cmd_ok && !IN_RESET_STATE) begin
      unique case (cmd)
        CMD_SET_RESTART_BLOCK: begin
          if (CMD_DATA == `SL_KEY_AA) s_d.restart_block = 1'b1;
        end
        CMD_CLEAR_RESTART_BLOCK: begin
          if (CMD_DATA == `SL_KEY_55) s_d.restart_block = 1'b0;
        end
        CMD_SET_CONFIG_LOCK: begin
          if (CMD_DATA == `SL_KEY_55 && DEVICE_STATE_CODE == ST_DIAG) s_d.cfg_lock = 1'b1;
        end
        CMD_CLEAR_CONFIG_LOCK: begin
          if (CMD_DATA == `SL_KEY_AA && DEVICE_STATE_CODE == ST_DIAG) s_d.cfg_lock = 1'b0;
        end
        CMD_SET_CONTROL_LOCK: begin
          if (CMD_DATA == `SL_KEY_55 && in_dsa) begin
            s_d.bist_lock = 1'b1;
            s_d.ctrl_lock = 1'b1;
          end
        end
        CMD_CLEAR_CONTROL_LOCK: begin
          if (CMD_DATA == `SL_KEY_AA && in_dsa) begin
            s_d.bist_lock = 1'b0;
            s_d.ctrl_lock = 1'b0;
          end
        end
        CMD_WRITE_CONFIG: begin
          s_d.wr_cfg = !s_q.cfg_lock;
          s_d.wdata  = CMD_DATA;
        end
        CMD_WRITE_SELFTEST: begin
          s_d.wr_bist = !s_q.bist_lock;
          s_d.wdata   = CMD_DATA;
        end
        CMD_WRITE_CONTROL: begin
          s_d.wr_ctrl = !s_q.ctrl_lock;
          s_d.wdata   = CMD_DATA;
        end
        CMD_READ_IDENTITY: begin
          s_d.rvalid = 1'b1;
          s_d.rdata  = identity;
        end
        CMD_READ_STATE_LOCKS: begin
          s_d.rvalid = 1'b1;
          s_d.rdata  = status;
        end
        default: begin
        end
      endcase
    end else if (cmd_ok) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = 8'h00;
    end
    // Hardware set events come after the commands so they win over a same-cycle clear
    if (left_diag || LOGIC_SELFTEST_DONE) begin
      s_d.cfg_lock  = 1'b1;
      s_d.ctrl_lock = 1'b1;
    end
    if (left_dsa || LOGIC_SELFTEST_DONE) s_d.bist_lock = 1'b1;
    if (REGULATOR_OVERVOLTAGE) s_d.restart_block = 1'b1;
    // Latch reload at reset release: kept value ORed with overvoltage, cleared if battery was lost
    if (!loaded_q) s_d.restart_block = BATTERY_LOST ? `SL_RESTART_RESET
                                                    : (RESTART_BLOCK_KEPT | REGULATOR_OVERVOLTAGE);
  end

  // Off state removes power, so RESETN low models the return from it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '{cfg_lock: `SL_LOCK_RESET, bist_lock: `SL_LOCK_RESET,
               ctrl_lock: `SL_LOCK_RESET, restart_block: `SL_RESTART_RESET,
               in_reset: 1'b1, prev_state: 3'h0, rdata: 8'h00, rvalid: 1'b0,
               wr_cfg: 1'b0, wr_bist: 1'b0, wr_ctrl: 1'b0, wdata: 8'h00};
      loaded_q <= 1'b0;
    end else begin
      s_q <= s_d;
      loaded_q <= 1'b1;
    end
  end

  assign RESP_VALID         = s_q.rvalid;
  assign RESP_DATA          = s_q.rdata;
  assign CONFIG_WRITE       = s_q.wr_cfg;
  assign SELFTEST_WRITE     = s_q.wr_bist;
  assign CONTROL_WRITE      = s_q.wr_ctrl;
  assign WRITE_DATA         = s_q.wdata;
  assign CONFIG_LOCKED      = s_q.cfg_lock;
  assign SELFTEST_LOCKED    = s_q.bist_lock;
  assign CONTROL_LOCKED     = s_q.ctrl_lock;
  // Sequencer uses this on reaching off with wake high
  assign AUTO_RESTART_BLOCK = s_q.restart_block;
  assign RESET_EXTENSION_CYCLES = identity[`SL_EXT_SEL_BIT] ? 32'(EXT_SHORT_CYC)
                                                             : 32'(EXT_LONG_CYC);

  a_reset_zero_read: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && IN_RESET_STATE) |=> (RESP_VALID && RESP_DATA == 8'h00))
    else $error("read in reset state not zero");
  a_ovp_sets_latch: assert property (@(posedge CLK) disable iff (!RESETN)
    (REGULATOR_OVERVOLTAGE && loaded_q) |=> AUTO_RESTART_BLOCK)
    else $error("overvoltage did not set restart latch");
  a_cfg_clear_diag: assert property (@(posedge CLK) disable iff (!RESETN)
    ($fell(CONFIG_LOCKED)) |-> ($past(DEVICE_STATE_CODE) == ST_DIAG && $past(CMD_DATA) == `SL_KEY_AA))
    else $error("config lock cleared outside diagnostic");
  a_cfg_exit_set: assert property (@(posedge CLK) disable iff (!RESETN)
    ($past(DEVICE_STATE_CODE) == ST_DIAG && DEVICE_STATE_CODE != ST_DIAG) |=> CONFIG_LOCKED)
    else $error("config lock not set on diagnostic exit");
  a_locked_write_block: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && cmd == CMD_WRITE_CONTROL && CONTROL_LOCKED) |=> !CONTROL_WRITE)
    else $error("control write passed a set lock");
  a_bist_lock_block: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && cmd == CMD_WRITE_SELFTEST && SELFTEST_LOCKED) |=> !SELFTEST_WRITE)
    else $error("selftest write passed a set lock");
  a_cfg_lock_block: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && cmd == CMD_WRITE_CONFIG && CONFIG_LOCKED) |=> !CONFIG_WRITE)
    else $error("config write passed a set lock");
  a_status_read: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_READ_STATE_LOCKS)
    |=> (RESP_VALID && RESP_DATA[7:5] == $past(DEVICE_STATE_CODE)))
    else $error("status read state field wrong");
  a_ctrl_clear_state: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(CONTROL_LOCKED) |-> ($past(in_dsa) && $past(CMD_DATA) == `SL_KEY_AA))
    else $error("control lock cleared illegally");
  a_ext_select: assert property (@(posedge CLK) disable iff (!RESETN)
    RESET_EXTENSION_CYCLES == (EXT_SHORT_SEL ? EXT_SHORT_CYC : EXT_LONG_CYC))
    else $error("reset extension count mismatch");

  // Keyed restart latch; overvoltage and the reset reload may override a clear
  a_restart_set_key: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_SET_RESTART_BLOCK && CMD_DATA == `SL_KEY_AA && loaded_q)
    |=> AUTO_RESTART_BLOCK)
    else $error("restart latch not set by key");

  a_restart_clear_key: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_CLEAR_RESTART_BLOCK && CMD_DATA == `SL_KEY_55
     && loaded_q && !REGULATOR_OVERVOLTAGE) |=> !AUTO_RESTART_BLOCK)
    else $error("restart latch not cleared by key");

  a_restart_rise: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(AUTO_RESTART_BLOCK) |-> ($past(REGULATOR_OVERVOLTAGE) || !$past(loaded_q)
                                   || $past(CMD_DATA) == `SL_KEY_AA))
    else $error("restart latch set without cause");

  // Reload at reset release decides between the kept value and a fresh start
  a_reload_battery_lost: assert property (@(posedge CLK) disable iff (!RESETN)
    (!loaded_q && BATTERY_LOST) |=> !AUTO_RESTART_BLOCK)
    else $error("restart latch kept after battery loss");

  a_reload_kept: assert property (@(posedge CLK) disable iff (!RESETN)
    (!loaded_q && !BATTERY_LOST && RESTART_BLOCK_KEPT) |=> AUTO_RESTART_BLOCK)
    else $error("restart latch lost across reset");

  // Hardware set events
  a_selftest_sets_locks: assert property (@(posedge CLK) disable iff (!RESETN)
    LOGIC_SELFTEST_DONE |=> (CONFIG_LOCKED && SELFTEST_LOCKED && CONTROL_LOCKED))
    else $error("selftest completion did not set locks");

  a_bist_exit_set: assert property (@(posedge CLK) disable iff (!RESETN)
    (loaded_q && $past(DEVICE_STATE_CODE) inside {ST_DIAG, ST_ACTIVE, ST_SAFE}
     && DEVICE_STATE_CODE != $past(DEVICE_STATE_CODE)) |=> SELFTEST_LOCKED)
    else $error("selftest lock not set on state exit");

  a_ctrl_exit_set: assert property (@(posedge CLK) disable iff (!RESETN)
    (loaded_q && $past(DEVICE_STATE_CODE) == ST_DIAG && DEVICE_STATE_CODE != ST_DIAG)
    |=> CONTROL_LOCKED)
    else $error("control lock not set on diagnostic exit");

  // Keyed lock commands
  a_cfg_set_key: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_SET_CONFIG_LOCK && CMD_DATA == `SL_KEY_55
     && DEVICE_STATE_CODE == ST_DIAG) |=> CONFIG_LOCKED)
    else $error("config lock not set by key");

  a_cfg_clear_key: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_CLEAR_CONFIG_LOCK && CMD_DATA == `SL_KEY_AA
     && DEVICE_STATE_CODE == ST_DIAG && !LOGIC_SELFTEST_DONE) |=> !CONFIG_LOCKED)
    else $error("config lock not cleared by key");

  a_ctrl_set_key: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_SET_CONTROL_LOCK && CMD_DATA == `SL_KEY_55 && in_dsa)
    |=> (SELFTEST_LOCKED && CONTROL_LOCKED))
    else $error("control locks not set by key");

  // Leaving diagnostic, active or safe in the same cycle wins over the selftest lock clear; leaving diagnostic or selftest completion wins over both
  a_ctrl_clear_key: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_CLEAR_CONTROL_LOCK && CMD_DATA == `SL_KEY_AA
     && in_dsa && loaded_q && DEVICE_STATE_CODE == $past(DEVICE_STATE_CODE) && !LOGIC_SELFTEST_DONE)
    |=> (!SELFTEST_LOCKED && !CONTROL_LOCKED))
    else $error("control locks not cleared by key");

  a_bist_clear_state: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(SELFTEST_LOCKED) |-> ($past(in_dsa) && $past(CMD_DATA) == `SL_KEY_AA))
    else $error("selftest lock cleared illegally");

  // Writes and reads
  a_cfg_write_pass: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_WRITE_CONFIG && !CONFIG_LOCKED)
    |=> (CONFIG_WRITE && WRITE_DATA == $past(CMD_DATA)))
    else $error("unlocked config write not passed");

  a_reset_no_write: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && IN_RESET_STATE) |=> !(CONFIG_WRITE || SELFTEST_WRITE || CONTROL_WRITE))
    else $error("write passed in reset state");

  a_identity_read: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_READ_IDENTITY)
    |=> (RESP_VALID && RESP_DATA[`SL_EXT_SEL_BIT] == EXT_SHORT_SEL))
    else $error("identity read wrong");

  a_status_locks: assert property (@(posedge CLK) disable iff (!RESETN)
    (CMD_VALID && !IN_RESET_STATE && cmd == CMD_READ_STATE_LOCKS)
    |=> (RESP_DATA[`SL_CFG_LOCK_BIT] == $past(CONFIG_LOCKED)
         && RESP_DATA[`SL_BIST_LOCK_BIT] == $past(SELFTEST_LOCKED)
         && RESP_DATA[`SL_CTRL_LOCK_BIT] == $past(CONTROL_LOCKED)
         && RESP_DATA[`SL_RESTART_BIT] == $past(AUTO_RESTART_BLOCK)))
    else $error("status read lock bits wrong");

endmodule // device_status_lock_regs

// ---- core/status_lock_params.svh ----
`ifndef STATUS_LOCK_PARAMS_SVH
`define STATUS_LOCK_PARAMS_SVH

// Status register field positions
`define SL_STATE_HI        7
`define SL_STATE_LO        5
`define SL_RESTART_BIT     3
`define SL_CFG_LOCK_BIT    2
`define SL_BIST_LOCK_BIT   1
`define SL_CTRL_LOCK_BIT   0
// Identity register field
`define SL_EXT_SEL_BIT     4
// Keys
`define SL_KEY_AA          8'haa
`define SL_KEY_55          8'h55
// Reset values
`define SL_LOCK_RESET      1'b1
`define SL_RESTART_RESET   1'b0
// Extension delays in ms
`define SL_EXT_LONG_MS     32
`define SL_EXT_SHORT_MS    2
`define SL_CLK_PER_MS      100000

`endif

// ---- core/status_lock_pkg.sv ----
package status_lock_pkg;
  // Device state codes as reported in the status register
  typedef enum logic [2:0] {
    ST_UNUSED = 3'h0,
    ST_DIAG   = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_SAFE   = 3'h4
  } dev_state_t;

  // Command codes presented by the serial front end
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_READ_IDENTITY,
    CMD_READ_STATE_LOCKS,
    CMD_SET_RESTART_BLOCK,
    CMD_CLEAR_RESTART_BLOCK,
    CMD_SET_CONFIG_LOCK,
    CMD_CLEAR_CONFIG_LOCK,
    CMD_SET_CONTROL_LOCK,
    CMD_CLEAR_CONTROL_LOCK,
    CMD_WRITE_CONFIG,
    CMD_WRITE_SELFTEST,
    CMD_WRITE_CONTROL
  } cmd_t;

  // Registered state of the block: locks, restart latch, response and pending write
  typedef struct packed {
    logic       cfg_lock;
    logic       bist_lock;
    logic       ctrl_lock;
    logic       restart_block;
    logic       in_reset;
    logic [2:0] prev_state;
    logic [7:0] rdata;
    logic       rvalid;
    logic       wr_cfg;
    logic       wr_bist;
    logic       wr_ctrl;
    logic [7:0] wdata;
  } sl_state_t;
endpackage

// ---- tb/device_status_lock_regs_bench.sv ----
module device_status_lock_regs_bench import status_lock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [2:0]  st = ST_DIAG;
  logic        in_rst = 1'b0, st_done = 1'b0, ov = 1'b0, batt = 1'b0, kept = 1'b1;
  logic        cmd_valid, resp_valid, cfg_wr, bist_wr, ctrl_wr, cfg_l, bist_l, ctrl_l, blk;
  logic [3:0]  cmd_code;
  logic [7:0]  cmd_data, resp_data, wr_data, d;
  logic [31:0] ext_cyc;
  logic        e_blk = 1'b1, e_cfg = 1'b1, e_bist = 1'b1, e_ctrl = 1'b1;
  logic [7:0]  expq[$];
  int          errors = 0, checks_done = 0, seed = 32'h196e;

  always #5 clk = ~clk;

  device_status_lock_regs #(.EXT_SHORT_SEL(1'b1), .EXT_LONG_CYC(100), .EXT_SHORT_CYC(10)) uut (
    .CLK(clk), .RESETN(resetn), .DEVICE_STATE_CODE(st), .IN_RESET_STATE(in_rst),
    .LOGIC_SELFTEST_DONE(st_done), .REGULATOR_OVERVOLTAGE(ov), .BATTERY_LOST(batt),
    .RESTART_BLOCK_KEPT(kept), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_DATA(cmd_data),
    .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .CONFIG_WRITE(cfg_wr), .SELFTEST_WRITE(bist_wr),
    .CONTROL_WRITE(ctrl_wr), .WRITE_DATA(wr_data), .CONFIG_LOCKED(cfg_l), .SELFTEST_LOCKED(bist_l),
    .CONTROL_LOCKED(ctrl_l), .AUTO_RESTART_BLOCK(blk), .RESET_EXTENSION_CYCLES(ext_cyc));

  host_cmd_model host (.CLK(clk), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_DATA(cmd_data));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_stat();
    expq.push_back({st, 1'b0, e_blk, e_cfg, e_bist, e_ctrl});
    host.send(CMD_READ_STATE_LOCKS, 8'h00);
  endtask

  task automatic cmd(input cmd_t c, input logic [7:0] k);
    host.send(c, k);
    rd_stat();
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic test_done();
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Responses are registered on the taking edge and checked at the falling edge after it, in request order
  always @(negedge clk) begin
    if (resp_valid === 1'b1) begin
      if (expq.size() == 0)
        chk("unexpected response", 32'h0, 32'h1);
      else
        chk("response", expq.pop_front(), resp_data);
    end
  end

  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    rd_stat();
    expq.push_back(8'h10);
    host.send(CMD_READ_IDENTITY, 8'h00);
    chk("extension", 32'd10, ext_cyc);
    e_blk = 1'b0;
    cmd(CMD_CLEAR_RESTART_BLOCK, 8'h55);
    e_blk = 1'b1;
    cmd(CMD_SET_RESTART_BLOCK, 8'haa);
    e_blk = 1'b0;
    cmd(CMD_CLEAR_RESTART_BLOCK, 8'h55);
    pulse(ov);
    e_blk = 1'b1;
    rd_stat();
    e_cfg = 1'b0;
    cmd(CMD_CLEAR_CONFIG_LOCK, 8'haa);
    host.send(CMD_WRITE_CONFIG, 8'h3c);
    chk("config write", 32'h13c, {cfg_wr, wr_data});
    e_cfg = 1'b1;
    cmd(CMD_SET_CONFIG_LOCK, 8'h55);
    e_cfg = 1'b0;
    cmd(CMD_CLEAR_CONFIG_LOCK, 8'haa);
    @(negedge clk);
    st = ST_ACTIVE;
    e_cfg = 1'b1;
    rd_stat();
    cmd(CMD_CLEAR_CONFIG_LOCK, 8'haa);
    host.send(CMD_WRITE_CONFIG, 8'h5a);
    chk("config write", 32'h0, cfg_wr);
    // Wrong keys must leave every lock alone
    repeat (4) begin
      d = 8'($random(seed));
      if (d == 8'haa)
        d = 8'h00;
      cmd(CMD_CLEAR_CONTROL_LOCK, d);
    end
    e_bist = 1'b0;
    e_ctrl = 1'b0;
    cmd(CMD_CLEAR_CONTROL_LOCK, 8'haa);
    host.send(CMD_WRITE_SELFTEST, 8'h11);
    chk("selftest write", 32'h1, bist_wr);
    host.send(CMD_WRITE_CONTROL, 8'h22);
    chk("control write", 32'h1, ctrl_wr);
    pulse(st_done);
    {e_cfg, e_bist, e_ctrl} = 3'h7;
    rd_stat();
    host.send(CMD_WRITE_CONTROL, 8'h33);
    chk("control write", 32'h0, ctrl_wr);
    @(negedge clk);
    st = ST_SAFE;
    {e_bist, e_ctrl} = 2'h0;
    cmd(CMD_CLEAR_CONTROL_LOCK, 8'haa);
    @(negedge clk);
    st = ST_ACTIVE;
    e_bist = 1'b1;
    rd_stat();
    @(negedge clk);
    in_rst = 1'b1;
    expq.push_back(8'h00);
    host.send(CMD_READ_STATE_LOCKS, 8'h00);
    in_rst = 1'b0;
    // Power-on reset after battery loss: latch starts fresh, locks return to one
    @(negedge clk);
    batt = 1'b1;
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    {e_blk, e_cfg, e_bist, e_ctrl} = 4'h7;
    rd_stat();
    for (int i = 0; i < 20 && expq.size() != 0; i++)
      @(negedge clk);
    if (expq.size() != 0) begin
      errors++;
      $display("Error pending responses expected 0 seen %0d", expq.size());
    end
    test_done();
  end
endmodule // device_status_lock_regs_bench

// ---- tb/host_cmd_model.sv ----
module host_cmd_model import status_lock_pkg::*;
(
  // Clock
  input  wire logic       CLK,
  // Command toward the block
  output logic            CMD_VALID,
  output logic [3:0]      CMD_CODE,
  output logic [7:0]      CMD_DATA
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    CMD_VALID = 1'b0;
    CMD_CODE  = 4'h0;
    CMD_DATA  = 8'h00;
  end

  // One command per call, held across its taking edge; keys and reads use the dedicated codes
  task automatic send(input cmd_t code, input logic [7:0] data);
    @(negedge CLK);
    CMD_VALID = 1'b1;
    CMD_CODE  = code;
    CMD_DATA  = data;
    @(negedge CLK);
    CMD_VALID = 1'b0;
    // Released data is inverted, so a released 8'haa key reads as the other key 8'h55 while CMD_VALID is low
    CMD_DATA  = ~data;
  endtask
endmodule // host_cmd_model
